// [design/fuse_prog_consts.svh]
// Timing constants and field layout for the fuse array programming sequencer.
`ifndef FUSE_PROG_CONSTS_SVH
`define FUSE_PROG_CONSTS_SVH
`define FAPS_CLK_MHZ 250
`define FAPS_ADDR_W 11
`define FAPS_OUT_W 8
`define FAPS_EQ_LSB 8
`define FAPS_PROD_LSB 5
`define FAPS_PAIR_LSB 1
`define FAPS_COMP_BIT 0
`define FAPS_T0_NS 500
`define FAPS_T1_NS 500
`define FAPS_T2_NS 500
`define FAPS_T3_NS 500
`define FAPS_T4_NS 400
`define FAPS_T7_NS 400
`define FAPS_T5_NS 500
`define FAPS_TP_US 10
`define FAPS_TP_MAX_US 30
`define FAPS_MAX_ON_US 5000
`define FAPS_RAMP_NS 2000
`define FAPS_MAX_RETRY 15
`define FAPS_CYC_NS(ns) (((ns) * `FAPS_CLK_MHZ + 999) / 1000)
`define FAPS_CYC_US(us) ((us) * `FAPS_CLK_MHZ)
`endif

// [design/faps_pkg.sv]
// Types for the fuse array programming sequencer.
package faps_pkg;
    typedef enum logic [3:0] {
        FAPS_IDLE,
        FAPS_POWER,
        FAPS_ARR_RAMP,
        FAPS_SETTLE,
        FAPS_PULSE_RAMP,
        FAPS_PULSE,
        FAPS_RECOVER,
        FAPS_SAMPLE,
        FAPS_HOLD,
        FAPS_DONE
    } faps_state_t;
endpackage : faps_pkg

// [design/faps_sequencer.sv]
// Host-side sequencer that programs and verifies fuses through the device pins.
// How it works
// (RULE1) All supplies rise together; array supply never ahead of main supply.
// (RULE2) Output pins are left undriven while array fuses are programmed.
// (RULE3) After power-up interval, array supply ramps to programming level.
// (RULE4) Eleven address lines select an array fuse; output pins select polarity.
// (RULE5) Pulse supply rises only after array settle and address set-up time.
// (RULE6) Pulse supply held at programming level for the pulse width.
// (RULE7) After pulse, wait verify-valid delay, then sample verify output low.
// (RULE8) An intact fuse may be pulsed again up to fifteen more times.
// (RULE9) Each further fuse repeats address through verify within power limits.
// (RULE10) Standalone verify: array supply high, pulse supply normal.
// (RULE11) Verify output sampled after its valid delay from array supply rise.
// (RULE12) Each power application stays under 5 ms, duty at most 20 percent.
// (RULE13) Wait 400 ns after pulse before address change or array supply drop.
// (RULE14) Output pins matter only for polarity and security fuses.
// (RULE15) Undriven output pins are pulled low inside the device.
// (RULE16) Security fuse: polarity sequence with all eight outputs high.
// (RULE17) A secured device no longer reports array fuse state.
// (RULE18) Address fields: equation 3, product 3, input pair 4, complement 1.
// (RULE19) Polarity fuse intact gives active high output, opened gives low.
// (RULE20) Fuse still intact after retries stops the sequence with failure.
`timescale 1ns/1ps
`default_nettype none
`include "fuse_prog_consts.svh"
module faps_sequencer
    import faps_pkg::*;
#(
    parameter int ADDR_W = `FAPS_ADDR_W,
    parameter int OUT_W = `FAPS_OUT_W,
    parameter int MAX_RETRY = `FAPS_MAX_RETRY,
    parameter int PULSE_CYC = `FAPS_CYC_US(`FAPS_TP_US),
    parameter int OFF_FACTOR = 4
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic verify_only_i,
    input wire logic [2:0] eq_sel_i,
    input wire logic [2:0] prod_sel_i,
    input wire logic [3:0] pair_sel_i,
    input wire logic comp_sel_i,
    input wire logic [OUT_W-1:0] pol_sel_i,
    input wire logic verify_output_i,
    output logic busy_o,
    output logic done_o,
    output logic pass_o,
    output logic fail_o,
    output logic [3:0] attempts_o,
    output logic supply_on_o,
    output logic array_program_supply_o,
    output logic pulse_supply_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [OUT_W-1:0] out_pin_o,
    output logic [OUT_W-1:0] out_pin_oe_o
);
    localparam int T0_CYC = `FAPS_CYC_NS(`FAPS_T0_NS);
    localparam int RAMP_CYC = `FAPS_CYC_NS(`FAPS_RAMP_NS);
    localparam int T12_CYC = `FAPS_CYC_NS(`FAPS_T1_NS);
    localparam int T3_CYC = `FAPS_CYC_NS(`FAPS_T3_NS);
    localparam int T47_CYC = `FAPS_CYC_NS(`FAPS_T4_NS);
    localparam int T5_CYC = `FAPS_CYC_NS(`FAPS_T5_NS);
    localparam int CNT_W = 32;
    // Worst case: every retry used, all of it under one power application.
    localparam int FIRST_CYC = T0_CYC + RAMP_CYC + T47_CYC + 3;
    localparam int ATTEMPT_CYC = T12_CYC + RAMP_CYC + PULSE_CYC + T3_CYC + 4;
    localparam int WORST_CYC = FIRST_CYC + (MAX_RETRY + 1) * ATTEMPT_CYC;
    localparam int MAX_ON_CYC = `FAPS_CYC_US(`FAPS_MAX_ON_US);
    localparam int PULSE_MAX_CYC = `FAPS_CYC_US(`FAPS_TP_MAX_US);

    // The address packing and the pin loop are written for this one pin layout.
    if (ADDR_W != `FAPS_ADDR_W || OUT_W != `FAPS_OUT_W) begin : g_bad_width
        $error("faps_sequencer: unsupported pin widths");
    end
    // The attempt counter is four bits wide, so fifteen retries is its ceiling.
    if (MAX_RETRY < 0 || MAX_RETRY > `FAPS_MAX_RETRY) begin : g_bad_retry
        $error("faps_sequencer: unsupported retry count");
    end
    // (RULE6) Pulse width ceiling.
    if (PULSE_CYC < 1 || PULSE_CYC > PULSE_MAX_CYC) begin : g_bad_pulse
        $error("faps_sequencer: unsupported pulse length");
    end
    // (RULE12) Duty cycle ceiling.
    if (OFF_FACTOR < 4) begin : g_bad_duty
        $error("faps_sequencer: unsupported off factor");
    end
    // (RULE12) Power-on ceiling.
    if (WORST_CYC > MAX_ON_CYC) begin : g_bad_on_time
        $error("faps_sequencer: sequence exceeds power-on limit");
    end

    // Counters are full width, so no sequence that the checks allow can wrap them.
    faps_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] on_cnt_reg, on_cnt_next;
    logic [CNT_W-1:0] off_cnt_reg, off_cnt_next;
    logic [3:0] retry_reg, retry_next;
    logic vo_only_reg, vo_only_next;
    logic pol_mode_reg, pol_mode_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [OUT_W-1:0] pol_reg, pol_next;
    logic pass_reg, pass_next;
    logic fail_reg, fail_next;
    logic done_reg, done_next;
    logic ver_s1_reg, ver_s2_reg;

    wire cnt_zero = (cnt_reg == '0);
    wire [ADDR_W-1:0] addr_word;
    wire fuse_open = ~ver_s2_reg;
    // (RULE12) Off time against on time.
    wire duty_ok = (off_cnt_reg >= on_cnt_reg * OFF_FACTOR);
    // A refused start leaves no trace, so the caller holds start until busy rises.
    wire take_start = (state_reg == FAPS_IDLE) && start_i && duty_ok;
    wire supplies_on = (state_reg != FAPS_IDLE) && (state_reg != FAPS_DONE);
    // The array supply counts as raised while it ramps, so settling starts after it.
    wire array_high = (state_reg == FAPS_ARR_RAMP) || (state_reg == FAPS_SETTLE)
        || (state_reg == FAPS_PULSE_RAMP) || (state_reg == FAPS_PULSE)
        || (state_reg == FAPS_RECOVER) || (state_reg == FAPS_SAMPLE)
        || (state_reg == FAPS_HOLD);
    wire pulse_high = (state_reg == FAPS_PULSE_RAMP) || (state_reg == FAPS_PULSE);
    wire retry_left = (retry_reg < 4'(MAX_RETRY));

    // (RULE18) Address field packing.
    assign addr_word[`FAPS_EQ_LSB +: 3] = eq_sel_i;
    assign addr_word[`FAPS_PROD_LSB +: 3] = prod_sel_i;
    assign addr_word[`FAPS_PAIR_LSB +: 4] = pair_sel_i;
    assign addr_word[`FAPS_COMP_BIT] = comp_sel_i;

    // Verify output comes from another chip, so it is synchronised first.
    // It resets to the intact level, so nothing reads as opened before a real sample.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ver_s1_reg <= 1'b1;
            ver_s2_reg <= 1'b1;
        end else begin
            ver_s1_reg <= verify_output_i;
            ver_s2_reg <= ver_s1_reg;
        end
    end

    // Next-state logic; counters count and done clears by default, the rest hold unless a branch says otherwise.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
        retry_next = retry_reg;
        vo_only_next = vo_only_reg;
        pol_mode_next = pol_mode_reg;
        addr_next = addr_reg;
        pol_next = pol_reg;
        pass_next = pass_reg;
        fail_next = fail_reg;
        done_next = 1'b0;
        // (RULE12) Power-on time and off-time accounting.
        on_cnt_next = supplies_on ? on_cnt_reg + 1'b1 : on_cnt_reg;
        off_cnt_next = supplies_on ? '0 : off_cnt_reg + (duty_ok ? '0 : 32'h1);
        unique case (state_reg)
            FAPS_IDLE: begin
                // (RULE12) Duty cycle gate.
                if (take_start) begin
                    vo_only_next = verify_only_i;
                    // (RULE4) Address or output pin select.
                    addr_next = addr_word;
                    pol_next = pol_sel_i;
                    pol_mode_next = (pol_sel_i != '0);
                    retry_next = '0;
                    pass_next = 1'b0;
                    fail_next = 1'b0;
                    on_cnt_next = '0;
                    // (RULE1) Supplies together.
                    cnt_next = CNT_W'(T0_CYC);
                    state_next = FAPS_POWER;
                end
            end
            FAPS_POWER: begin
                // (RULE3) Array supply ramp.
                if (cnt_zero) begin
                    cnt_next = CNT_W'(RAMP_CYC);
                    state_next = FAPS_ARR_RAMP;
                end
            end
            FAPS_ARR_RAMP: begin
                if (cnt_zero) begin
                    // (RULE10) Standalone verify path.
                    cnt_next = vo_only_reg ? CNT_W'(T5_CYC) : CNT_W'(T12_CYC);
                    state_next = vo_only_reg ? FAPS_RECOVER : FAPS_SETTLE;
                end
            end
            FAPS_SETTLE: begin
                // (RULE5) Settle and set-up before pulse.
                if (cnt_zero) begin
                    cnt_next = CNT_W'(RAMP_CYC);
                    state_next = FAPS_PULSE_RAMP;
                end
            end
            FAPS_PULSE_RAMP: begin
                if (cnt_zero) begin
                    cnt_next = CNT_W'(PULSE_CYC);
                    state_next = FAPS_PULSE;
                end
            end
            FAPS_PULSE: begin
                // (RULE6) Hold pulse width.
                if (cnt_zero) begin
                    cnt_next = CNT_W'(T3_CYC);
                    state_next = FAPS_RECOVER;
                end
            end
            FAPS_RECOVER: begin
                // (RULE7) Verify-valid delay.
                if (cnt_zero) begin
                    state_next = FAPS_SAMPLE;
                end
            end
            FAPS_SAMPLE: begin
                // (RULE7) Low means opened.
                // (RULE17) A secured part reads intact, so security shows as fail.
                if (fuse_open) begin
                    pass_next = 1'b1;
                    cnt_next = CNT_W'(T47_CYC);
                    state_next = FAPS_HOLD;
                end else if (!vo_only_reg && retry_left) begin
                    // (RULE8) Another pulse.
                    // Retries resume at the settle step with the address still held.
                    retry_next = retry_reg + 1'b1;
                    cnt_next = CNT_W'(T12_CYC);
                    state_next = FAPS_SETTLE;
                end else begin
                    // (RULE20) Retries exhausted.
                    fail_next = 1'b1;
                    cnt_next = CNT_W'(T47_CYC);
                    state_next = FAPS_HOLD;
                end
            end
            FAPS_HOLD: begin
                // (RULE13) Hold address and array supply.
                if (cnt_zero) begin
                    state_next = FAPS_DONE;
                end
            end
            FAPS_DONE: begin
                // (RULE9) Ready for the next fuse.
                done_next = 1'b1;
                state_next = FAPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= FAPS_IDLE;
            cnt_reg <= '0;
            on_cnt_reg <= '0;
            off_cnt_reg <= '0;
            retry_reg <= '0;
            vo_only_reg <= 1'b0;
            pol_mode_reg <= 1'b0;
            addr_reg <= '0;
            pol_reg <= '0;
            pass_reg <= 1'b0;
            fail_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            on_cnt_reg <= on_cnt_next;
            off_cnt_reg <= off_cnt_next;
            retry_reg <= retry_next;
            vo_only_reg <= vo_only_next;
            pol_mode_reg <= pol_mode_next;
            addr_reg <= addr_next;
            pol_reg <= pol_next;
            pass_reg <= pass_next;
            fail_reg <= fail_next;
            done_reg <= done_next;
        end
    end

    // Busy is decoded from the state, so a taken start shows on the next cycle.
    assign busy_o = (state_reg != FAPS_IDLE);
    assign done_o = done_reg;
    assign pass_o = pass_reg;
    assign fail_o = fail_reg;
    assign attempts_o = retry_reg;
    // (RULE1) Main supply is on in every state but idle and done, the array supply's window included.
    assign supply_on_o = supplies_on;
    assign array_program_supply_o = array_high;
    assign pulse_supply_o = pulse_high;
    assign addr_o = addr_reg;

    // (RULE2) Output pins driven only in polarity or security mode.
    // (RULE16) Security fuse uses all-ones select.
    // Unselected pins are released; the device's pull-downs then hold them low.
    wire pins_live = pol_mode_reg && supplies_on;
    genvar g;
    generate
        for (g = 0; g < OUT_W; g++) begin : g_out
            assign out_pin_o[g] = pol_reg[g];
            assign out_pin_oe_o[g] = pins_live && pol_reg[g];
        end
    endgenerate
endmodule : faps_sequencer
`default_nettype wire

// [verif/faps_checker.sv]
// Port checker for the fuse programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module faps_checker #(parameter int PULSE_CYC = 20, parameter int RAMP_CYC = 500) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic done_o,
    input wire logic pass_o,
    input wire logic fail_o,
    input wire logic supply_on_o,
    input wire logic array_program_supply_o,
    input wire logic pulse_supply_o,
    input wire logic [10:0] addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [11:0] ac_reg, pc_reg, gc_reg, sc_reg;
    // Counters other than pc_reg saturate so a long idle gap never wraps to a small value.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ac_reg <= 12'h000;
            pc_reg <= 12'h000;
            gc_reg <= 12'h000;
            sc_reg <= 12'h000;
        end else begin
            sc_reg <= supply_on_o ? sc_reg + {11'h000, ~&sc_reg} : 12'h000;
            ac_reg <= array_program_supply_o ? ac_reg + {11'h000, ~&ac_reg} : 12'h000;
            pc_reg <= pulse_supply_o ? pc_reg + 12'h001 : 12'h000;
            gc_reg <= pulse_supply_o ? 12'h000 : gc_reg + {11'h000, ~&gc_reg};
        end
    end
    sequence s_pulse_end; $fell(pulse_supply_o); endsequence
    property p_order; array_program_supply_o |-> supply_on_o; endproperty
    a_order: assert property (p_order) else $error("array supply without power");
    property p_pulse; pulse_supply_o |-> array_program_supply_o && supply_on_o; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse without array supply");
    property p_power; $rose(array_program_supply_o) |-> sc_reg >= 12'h07D; endproperty
    a_power: assert property (p_power) else $error("array supply raised too early");
    // The array ramp counts as raised time, so settling adds to the ramp.
    property p_settle; $rose(pulse_supply_o) |-> ac_reg >= RAMP_CYC + 125; endproperty
    a_settle: assert property (p_settle) else $error("pulse before settle");
    // The raised pulse supply spans its ramp, the pulse itself and two state steps.
    property p_width;
        s_pulse_end |-> pc_reg >= PULSE_CYC + RAMP_CYC && pc_reg <= PULSE_CYC + RAMP_CYC + 2;
    endproperty
    a_width: assert property (p_width) else $error("pulse width wrong");
    property p_recover; $fell(array_program_supply_o) |-> gc_reg >= 12'h064; endproperty
    a_recover: assert property (p_recover) else $error("array supply dropped early");
    property p_addr; array_program_supply_o |-> $stable(addr_o); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_done; done_o |=> !done_o; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_excl; !(pass_o && fail_o); endproperty
    a_excl: assert property (p_excl) else $error("pass and fail together");
endmodule : faps_checker
bind faps_sequencer faps_checker #(.PULSE_CYC(PULSE_CYC), .RAMP_CYC(RAMP_CYC)) u_chk (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .done_o(done_o), .pass_o(pass_o), .fail_o(fail_o),
    .supply_on_o(supply_on_o), .array_program_supply_o(array_program_supply_o),
    .pulse_supply_o(pulse_supply_o), .addr_o(addr_o));
`default_nettype wire

// [verif/faps_fuse_model.sv]
// Behavioural model of the fuse device behind its programming pins.
`timescale 1ns/1ps
`default_nettype none
module faps_fuse_model (
    input wire logic clk_i,
    input wire logic [4:0] need_i,
    input wire logic supply_on_i,
    input wire logic arr_i,
    input wire logic pulse_i,
    input wire logic [10:0] addr_i,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] oe_i,
    output logic verify_output_o
);
    logic [2047:0] fuse_reg = {2048{1'b1}};
    // intact polarity fuse keeps the output active high.
    logic [7:0] pol_reg = 8'hFF;
    logic sec_reg = 1'b0;
    logic arr_reg = 1'b0;
    logic pul_reg = 1'b0;
    logic tog_reg = 1'b0;
    logic [4:0] hits_reg = 5'h00;
    wire logic [7:0] sel = pin_i & oe_i;
    wire logic [4:0] hits_next = hits_reg + 5'h01;
    wire logic val = (sel == 8'hFF) ? ~sec_reg : (sel != 8'h00) ? |(pol_reg & sel) :
        sec_reg | fuse_reg[addr_i];
    always @(posedge clk_i) begin
        arr_reg <= arr_i;
        pul_reg <= pulse_i;
        tog_reg <= ~tog_reg;
        if (arr_i && !arr_reg) hits_reg <= 5'h00;
        if (pul_reg && !pulse_i) begin
            hits_reg <= hits_next;
            if (hits_next >= need_i && sel == 8'hFF) sec_reg <= 1'b1;
            else if (hits_next >= need_i && sel != 8'h00) pol_reg <= pol_reg & ~sel;
            else if (hits_next >= need_i) fuse_reg[addr_i] <= 1'b0;
        end
    end
    // valid only outside the pulse; a changing pattern otherwise.
    assign verify_output_o = (supply_on_i && arr_i && !pulse_i) ? val : tog_reg;
endmodule : faps_fuse_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the fuse programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start = 1'b0;
    logic vonly = 1'b0;
    logic [10:0] fa = 11'h000;
    logic [7:0] pol = 8'h00;
    logic [4:0] need = 5'h01;
    logic busy, done, pass, fail, son, arr, pul, verify_output;
    logic [10:0] addr, cap;
    logic [7:0] pin, oe;
    logic [7:0] coe;
    logic [3:0] att;
    int n_mismatch = 0;
    int checks = 0;
    int npul = 0;
    always #2 clk_i = ~clk_i;
    always @(posedge pul) npul++;
    always @(posedge arr) cap = addr;
    always @(posedge arr) coe = pin & oe;
    faps_sequencer #(.PULSE_CYC(20)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .start_i(start), .verify_only_i(vonly), .eq_sel_i(fa[10:8]), .prod_sel_i(fa[7:5]),
        .pair_sel_i(fa[4:1]), .comp_sel_i(fa[0]), .pol_sel_i(pol), .verify_output_i(verify_output),
        .busy_o(busy), .done_o(done), .pass_o(pass), .fail_o(fail), .attempts_o(att),
        .supply_on_o(son), .array_program_supply_o(arr), .pulse_supply_o(pul),
        .addr_o(addr), .out_pin_o(pin), .out_pin_oe_o(oe));
    faps_fuse_model dev (.clk_i(clk_i), .need_i(need), .supply_on_i(son), .arr_i(arr),
        .pulse_i(pul), .addr_i(addr), .pin_i(pin), .oe_i(oe), .verify_output_o(verify_output));
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Start is held until taken, since the duty window may refuse it for a while.
    task automatic run(input logic v, input logic [10:0] a, input logic [7:0] p,
        input logic [4:0] n);
        int i;
        @(posedge clk_i);
        #1;
        vonly = v;
        fa = a;
        pol = p;
        need = n;
        npul = 0;
        start = 1'b1;
        for (i = 0; i < 30000 && busy !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        start = 1'b0;
        for (i = 0; i < 30000 && done !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(11'({busy, son, arr, pul}), 11'h000);
    endtask : run
    // A reset in mid-sequence must drop every supply and release the pins at once.
    task automatic t_reset;
        int i;
        @(posedge clk_i);
        #1;
        vonly = 1'b1;
        fa = 11'h7FF;
        pol = 8'h80;
        start = 1'b1;
        for (i = 0; i < 1000 && arr !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        start = 1'b0;
        chk(11'(pin & oe), 11'h080);
        reset_n_i = 1'b0;
        #1;
        chk(11'({busy, son, arr, pul}), 11'h000);
        chk(11'(oe), 11'h000);
        repeat (2) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        @(posedge clk_i);
        #1;
        chk(11'({busy, done, pass, fail, att}), 11'h000);
        $display("test reset ended");
    endtask : t_reset
    task automatic t_array;
        run(1'b0, 11'h5A5, 8'h00, 5'h01);
        chk(11'(pass), 11'h001);
        chk(11'(npul), 11'h001);
        chk(cap, 11'h5A5);
        chk(11'(coe), 11'h000);
        chk(11'(dev.fuse_reg[11'h5A5]), 11'h000);
        $display("test array ended");
    endtask : t_array
    task automatic t_retry;
        run(1'b0, 11'h000, 8'h00, 5'h04);
        chk(11'(pass), 11'h001);
        chk(11'(npul), 11'h004);
        chk(11'(att), 11'h003);
        $display("test retry ended");
    endtask : t_retry
    task automatic t_verify;
        run(1'b1, 11'h5A5, 8'h00, 5'h01);
        chk(11'(pass), 11'h001);
        chk(11'(npul), 11'h000);
        run(1'b1, 11'h7FF, 8'h00, 5'h01);
        chk(11'(fail), 11'h001);
        $display("test verify ended");
    endtask : t_verify
    task automatic t_polarity;
        run(1'b0, 11'h001, 8'h04, 5'h01);
        chk(11'(pass), 11'h001);
        chk(11'(dev.pol_reg), 11'h0FB);
        chk(11'(coe), 11'h004);
        chk(11'(dev.fuse_reg[11'h001]), 11'h001);
        $display("test polarity ended");
    endtask : t_polarity
    task automatic t_secure;
        run(1'b0, 11'h000, 8'hFF, 5'h01);
        chk(11'(pass), 11'h001);
        run(1'b1, 11'h5A5, 8'h00, 5'h01);
        chk(11'(fail), 11'h001);
        $display("test secure ended");
    endtask : t_secure
    task automatic t_fail;
        run(1'b0, 11'h7FF, 8'h00, 5'h1F);
        chk(11'(fail), 11'h001);
        chk(11'(npul), 11'h010);
        chk(11'(att), 11'h00F);
        $display("test fail ended");
    endtask : t_fail
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        t_reset();
        t_array();
        t_retry();
        t_verify();
        t_polarity();
        t_secure();
        t_fail();
        conclude();
    end
    // Sequences plus duty-cycle gaps take about 70000 cycles; this allows 100000.
    initial begin
        #400000;
        n_mismatch++;
        conclude();
    end
endmodule : tb
`default_nettype wire
